// file: design/dio_defines.svh
// Constants for the drive digital I/O state readback block.
// Assumes it is included by bare name from the package and the design.
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// Parameter numbers under which the two words are read.
`define DIO_PAR_INPUT     16'h0297
`define DIO_PAR_OUTPUT    16'h0298

// Field positions inside the two words.
`define DIO_BIT_NEG       0
`define DIO_BIT_POS       1
`define DIO_BIT_HOME      2
`define DIO_BIT_BRAKE     0
`define DIO_BIT_PHYS      16

// Channel counts and word width.
`define DIO_NUM_IN        3
`define DIO_NUM_OUT       2
`define DIO_WORD_W        32

// Function select code meaning that no channel is assigned.
`define DIO_SEL_NONE      2'h0

// Reset values of the words and the answer data.
`define DIO_WORD_RESET    32'h0000_0000

`endif

// file: design/dio_pkg.sv
// Types for the drive digital I/O state readback block.
// Assumes the constants header is on the include path.
`include "dio_defines.svh"

package dio_pkg;

    // Function assignment: a select of 0 means unassigned, n means channel n-1.
    typedef struct packed {
        logic [1:0] selNeg;
        logic [1:0] selPos;
        logic [1:0] selHome;
        logic [1:0] selBrake;
    } dio_cfg_s;

    // Parameter access request from the fieldbus side, one cycle long.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] num;
        logic [31:0] wdata;
    } dio_req_s;

    // Parameter access answer, ack is a one-cycle pulse.
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] data;
    } dio_rsp_s;

    // Whole registered state of the readback block.
    typedef struct packed {
        logic [31:0] inWord;
        logic [31:0] outWord;
        dio_rsp_s    rsp;
    } dio_state_s;

endpackage : dio_pkg

// file: design/dio_state_readback.sv
// Digital input and output state words of a servo drive, readable by
// parameter number from the fieldbus side.
// Assumes raw input pins are asynchronous, while the output states, the
// function configuration and the parameter requests come from logic on
// clk_sys.
`timescale 1ns/1ns
`include "dio_defines.svh"

module dio_state_readback
    import dio_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    // Physical channels
    input  wire logic [`DIO_NUM_IN-1:0]  pinIn,
    input  wire logic [`DIO_NUM_OUT-1:0] outState,
    // Function assignment
    input  wire dio_cfg_s                cfg,
    // Parameter access
    input  wire dio_req_s                req,
    output dio_rsp_s                     rsp,
    // Live state words
    output logic [`DIO_WORD_W-1:0]       inWord,
    output logic [`DIO_WORD_W-1:0]       outWord
);

    // All registered state in one word, so reset and update stay in step
    // and no output can lag another by an edge.
    dio_state_s st_reg;
    dio_state_s st_next;

    // Live words are built combinationally from the synchronised pins and
    // the same-clock output states; only their registered copy is visible.
    logic [`DIO_NUM_IN-1:0] syncIn;
    logic                   negSrc;
    logic                   posSrc;
    logic                   homeSrc;
    logic                   brakeSrc;
    logic [`DIO_WORD_W-1:0] inLive;
    logic [`DIO_WORD_W-1:0] outLive;
    logic                   isInNum;
    logic                   isOutNum;

    // Pins are asynchronous, so nothing reads them before two flip-flops.
    dio_sync #(
        .WIDTH    (`DIO_NUM_IN)
    ) uSync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .pinAsync (pinIn),
        .pinSync  (syncIn)
    );

    // Picks an input channel by select code; code zero picks nothing.
    function automatic logic pickIn(input logic [1:0] sel,
                                    input logic [`DIO_NUM_IN-1:0] bits);
        logic [1:0] idx;
        idx = sel - 2'h1;
        if (sel == `DIO_SEL_NONE)
            pickIn = 1'b0;
        else
            pickIn = bits[idx];
    endfunction : pickIn

    // Picks an output channel; codes beyond the channel count pick nothing.
    function automatic logic pickOut(input logic [1:0] sel,
                                     input logic [`DIO_NUM_OUT-1:0] bits);
        logic idx;
        idx = 1'(sel - 2'h1);
        if (sel == `DIO_SEL_NONE || sel > 2'(`DIO_NUM_OUT))
            pickOut = 1'b0;
        else
            pickOut = bits[idx];
    endfunction : pickOut

    // Function flags follow whichever channel software assigned.
    assign negSrc   = pickIn(cfg.selNeg, syncIn);
    assign posSrc   = pickIn(cfg.selPos, syncIn);
    assign homeSrc  = pickIn(cfg.selHome, syncIn);
    assign brakeSrc = pickOut(cfg.selBrake, outState);

    // Each word bit is built by position; unlisted positions stay zero.
    for (genvar b = 0; b < `DIO_WORD_W; b++) begin : gBits
        if (b == `DIO_BIT_NEG) begin : gNeg
            assign inLive[b] = negSrc;
        end else if (b == `DIO_BIT_POS) begin : gPos
            assign inLive[b] = posSrc;
        end else if (b == `DIO_BIT_HOME) begin : gHome
            assign inLive[b] = homeSrc;
        end else if (b >= `DIO_BIT_PHYS &&
                     b < `DIO_BIT_PHYS + `DIO_NUM_IN) begin : gInPhys
            assign inLive[b] = syncIn[b-`DIO_BIT_PHYS];
        end else begin : gInZero
            assign inLive[b] = 1'b0;
        end
        if (b == `DIO_BIT_BRAKE) begin : gBrake
            assign outLive[b] = brakeSrc;
        end else if (b >= `DIO_BIT_PHYS &&
                     b < `DIO_BIT_PHYS + `DIO_NUM_OUT) begin : gOutPhys
            assign outLive[b] = outState[b-`DIO_BIT_PHYS];
        end else begin : gOutZero
            assign outLive[b] = 1'b0;
        end
    end

    // Request decode against the two parameter numbers.
    assign isInNum  = (req.num == `DIO_PAR_INPUT);
    assign isOutNum = (req.num == `DIO_PAR_OUTPUT);

    // Next state: words refresh every cycle, a request is answered on the next edge.
    // Reads return the word as it stood when the request arrived, so an
    // answer never mixes two samples of the channels.
    always_comb begin
        st_next         = st_reg;
        st_next.inWord  = inLive;
        st_next.outWord = outLive;
        st_next.rsp.ack = 1'b0;
        if (req.valid) begin
            st_next.rsp.ack = 1'b1;
            if (req.write) begin
                // Both words are read-only; data is left as it was.
                st_next.rsp.err = 1'b1;
            end else if (isInNum) begin
                st_next.rsp.err  = 1'b0;
                st_next.rsp.data = st_reg.inWord;
            end else if (isOutNum) begin
                st_next.rsp.err  = 1'b0;
                st_next.rsp.data = st_reg.outWord;
            end else begin
                st_next.rsp.err  = 1'b1;
                st_next.rsp.data = `DIO_WORD_RESET;
            end
        end
    end

    // Single register for all state.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg.inWord   <= `DIO_WORD_RESET;
            st_reg.outWord  <= `DIO_WORD_RESET;
            st_reg.rsp.ack  <= 1'b0;
            st_reg.rsp.err  <= 1'b0;
            st_reg.rsp.data <= `DIO_WORD_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs all come straight from the state register.
    assign rsp     = st_reg.rsp;
    assign inWord  = st_reg.inWord;
    assign outWord = st_reg.outWord;

    // Checks on the words and the access path.
    default clocking cbMain @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence sReadIn;
        req.valid && !req.write && isInNum;
    endsequence

    sequence sReadOut;
        req.valid && !req.write && isOutNum;
    endsequence

    sequence sWrite;
        req.valid && req.write;
    endsequence

    // A read of a number that names neither word.
    sequence sReadBad;
        req.valid && !req.write && !isInNum && !isOutNum;
    endsequence

    // A routed flag must equal the mirror bit of the channel its select
    // names. Comparing against the mirror keeps the check independent of
    // the pick functions, so a wrong index there shows up here.
    property pRoute(logic [1:0] sel, logic flag, logic [2:0] mirror);
        (sel == 2'h1 |=> flag == mirror[0]) and
        (sel == 2'h2 |=> flag == mirror[1]) and
        (sel == 2'h3 |=> flag == mirror[2]);
    endproperty

    // Flags and mirrors follow their sources one edge later. The resetn
    // term skips the edge of release, at which the register is still held
    // clear while the sources may already be active.
    a_neg_flag: assert property (
        resetn |=> inWord[`DIO_BIT_NEG] == $past(negSrc))
        else $error("negative limit flag does not follow its input");

    a_pos_flag: assert property (
        resetn |=> inWord[`DIO_BIT_POS] == $past(posSrc))
        else $error("positive limit flag does not follow its input");

    a_home_flag: assert property (
        resetn |=> inWord[`DIO_BIT_HOME] == $past(homeSrc))
        else $error("home flag does not follow its input");

    a_neg_route: assert property (
        pRoute(cfg.selNeg, inWord[`DIO_BIT_NEG],
               inWord[`DIO_BIT_PHYS+`DIO_NUM_IN-1:`DIO_BIT_PHYS]))
        else $error("negative limit flag follows the wrong input");

    a_pos_route: assert property (
        pRoute(cfg.selPos, inWord[`DIO_BIT_POS],
               inWord[`DIO_BIT_PHYS+`DIO_NUM_IN-1:`DIO_BIT_PHYS]))
        else $error("positive limit flag follows the wrong input");

    a_home_route: assert property (
        pRoute(cfg.selHome, inWord[`DIO_BIT_HOME],
               inWord[`DIO_BIT_PHYS+`DIO_NUM_IN-1:`DIO_BIT_PHYS]))
        else $error("home flag follows the wrong input");

    // Code three names no output, so the padded mirror bit must read zero.
    a_brake_route: assert property (
        pRoute(cfg.selBrake, outWord[`DIO_BIT_BRAKE],
               {1'b0, outWord[`DIO_BIT_PHYS+`DIO_NUM_OUT-1:`DIO_BIT_PHYS]}))
        else $error("brake flag follows the wrong output");

    a_home_quiet: assert property (
        cfg.selHome == `DIO_SEL_NONE |=> inWord[`DIO_BIT_HOME] == 1'b0)
        else $error("unassigned home flag is set");

    a_brake_quiet: assert property (
        cfg.selBrake == `DIO_SEL_NONE
        |=> outWord[`DIO_BIT_BRAKE] == 1'b0)
        else $error("unassigned brake flag is set");

    a_unassigned_quiet: assert property (
        cfg.selNeg == `DIO_SEL_NONE && cfg.selPos == `DIO_SEL_NONE
        |=> inWord[`DIO_BIT_POS:`DIO_BIT_NEG] == 2'h0)
        else $error("unassigned limit flag is set");

    a_in_mirror: assert property (
        resetn |=> inWord[`DIO_BIT_PHYS+`DIO_NUM_IN-1:`DIO_BIT_PHYS]
            == $past(syncIn))
        else $error("input mirror bits disagree with inputs");

    a_in_polarity: assert property (
        syncIn[0] ##1 syncIn[0] |-> inWord[`DIO_BIT_PHYS])
        else $error("active input does not read as one");

    a_brake_flag: assert property (
        resetn |=> outWord[`DIO_BIT_BRAKE] == $past(brakeSrc))
        else $error("brake flag does not follow its output");

    a_out_mirror: assert property (
        resetn |=> outWord[`DIO_BIT_PHYS+`DIO_NUM_OUT-1:`DIO_BIT_PHYS]
            == $past(outState))
        else $error("output mirror bits disagree with outputs");

    // Output 0, when it is on, must read as one in its mirror bit.
    a_out_polarity: assert property (
        resetn && outState[0] |=> outWord[`DIO_BIT_PHYS])
        else $error("active output does not read as one");

    // Bits without a meaning read zero in every cycle out of reset.
    a_spare_zero: assert property (
        inWord[15:3] == 13'h0000 && inWord[31:19] == 13'h0000 &&
        outWord[15:1] == 15'h0000 && outWord[31:18] == 14'h0000)
        else $error("undefined word bit is set");

    // Access path: every request is answered on the next edge, and the
    // answer holds until another request arrives.
    a_read_in: assert property (
        sReadIn |=> rsp.ack && !rsp.err && rsp.data == $past(inWord))
        else $error("input word read returned wrong answer");

    a_read_out: assert property (
        sReadOut |=> rsp.ack && !rsp.err && rsp.data == $past(outWord))
        else $error("output word read returned wrong answer");

    a_write_ignored: assert property (
        sWrite |=> rsp.ack && rsp.err && $stable(rsp.data))
        else $error("write was not refused");

    a_ack_pulse: assert property (
        !req.valid |=> !rsp.ack)
        else $error("answer without a request");

    a_ack_latency: assert property (
        req.valid |=> rsp.ack)
        else $error("request was not answered on the next edge");

    a_unknown_num: assert property (
        sReadBad |=> rsp.ack && rsp.err && rsp.data == `DIO_WORD_RESET)
        else $error("unknown parameter number was not refused");

    // Without this a stray update of err or data between answers would go
    // unseen, since the bench samples only right after its own requests.
    a_idle_hold: assert property (
        !req.valid |=> $stable(rsp.err) && $stable(rsp.data))
        else $error("answer changed without a request");

endmodule : dio_state_readback

// file: design/dio_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`include "dio_defines.svh"

module dio_sync
    import dio_pkg::*;
#(
    parameter int WIDTH = `DIO_NUM_IN
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Pins and synchronised levels
    input  wire logic [WIDTH-1:0] pinAsync,
    output logic      [WIDTH-1:0] pinSync
);

    // Both stages live in one state word; the first is read only by the
    // second, so a metastable first stage never reaches any logic.
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } dio_sync_s;

    dio_sync_s st_reg;
    dio_sync_s st_next;

    // The first stage takes the pins, the second takes the first.
    always_comb begin
        st_next.stage1 = pinAsync;
        st_next.stage2 = st_reg.stage1;
    end

    // Clearing both stages keeps a released reset from showing stale pins.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Only the second stage is seen outside.
    assign pinSync = st_reg.stage2;

endmodule : dio_sync

// file: sim/dio_ctrl_model.sv
// Fieldbus controller model that reads and writes drive parameters.
// Assumes the drive takes a one-cycle strobe and answers one edge later.
`timescale 1ns/1ns

module dio_ctrl_model
    import dio_pkg::*;
(
    // Clock
    input  wire logic     clk_sys,
    // Parameter access
    output dio_req_s      req,
    input  wire dio_rsp_s rsp
);
    // The bus starts idle so nothing is taken during reset.
    initial begin
        req = '0;
    end

    // One access: a single-cycle strobe, then the answer after that edge.
    // Released lines are inverted so a late sample reads rubbish.
    task automatic access(input logic wr, input logic [15:0] num,
                          input logic [31:0] wdata, output dio_rsp_s ans);
        @(posedge clk_sys);
        req <= '{valid: 1'b1, write: wr, num: num, wdata: wdata};
        @(posedge clk_sys);
        req <= '{valid: 1'b0, write: ~wr, num: ~num, wdata: ~wdata};
        #1;
        ans = rsp;
    endtask : access
endmodule : dio_ctrl_model

// file: sim/drive_io_state_readback_bench.sv
// Self-checking bench for the digital I/O state readback block.
// Assumes the package and the controller model are compiled first.
`timescale 1ns/1ns
`include "dio_defines.svh"

module drive_io_state_readback_bench
    import dio_pkg::*;
;
    typedef struct packed {
        logic [2:0]  pin;
        logic [1:0]  outs;
        dio_cfg_s    cfg;
        logic [31:0] expIn;
        logic [31:0] expOut;
    } dio_row_s;

    logic                   clk_sys    = 1'b0;
    logic                   resetn     = 1'b0;
    logic [`DIO_NUM_IN-1:0] pinIn      = '0;
    logic [1:0]             outState   = '0;
    dio_cfg_s               cfg        = '0;
    dio_req_s               req;
    dio_rsp_s               rsp;
    dio_rsp_s               ans;
    logic [31:0]            inWord;
    logic [31:0]            outWord;
    int                     num_errors = 0;
    int                     comparisons = 0;
    int                     cycles     = 0;
    dio_row_s               rows [7];

    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;

    dio_state_readback dio_state_readback_i (
        .clk_sys(clk_sys), .resetn(resetn), .pinIn(pinIn),
        .outState(outState), .cfg(cfg), .req(req), .rsp(rsp),
        .inWord(inWord), .outWord(outWord));

    dio_ctrl_model dio_ctrl_model_i (
        .clk_sys(clk_sys), .req(req), .rsp(rsp));

    // Report the counts and the verdict, then end the run.
    task stop_test;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Compare one value, four-state, and count it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s saw %h want %h", $time, what,
                     seen, exp);
        end
    endtask : check

    // Let the two synchroniser stages and the word register settle.
    task automatic settle;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : settle

    // The whole run needs well under a thousand cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        rows[0] = '{3'h0, 2'h0, dio_cfg_s'(8'h00), 32'h0, 32'h0};
        rows[1] = '{3'h7, 2'h3, dio_cfg_s'(8'h00), 32'h0007_0000,
                    32'h0003_0000};
        rows[2] = '{3'h1, 2'h1, dio_cfg_s'(8'h6D), 32'h0001_0001,
                    32'h0001_0001};
        rows[3] = '{3'h2, 2'h2, dio_cfg_s'(8'h6D), 32'h0002_0002,
                    32'h0002_0000};
        rows[4] = '{3'h4, 2'h3, dio_cfg_s'(8'h6D), 32'h0004_0004,
                    32'h0003_0001};
        rows[5] = '{3'h7, 2'h2, dio_cfg_s'(8'hFE), 32'h0007_0007,
                    32'h0002_0001};
        rows[6] = '{3'h6, 2'h3, dio_cfg_s'(8'h57), 32'h0006_0000,
                    32'h0003_0000};
        repeat (3) @(posedge clk_sys);
        #1;
        check(inWord | outWord | rsp.data, 32'h0, "reset words");
        check({30'h0, rsp.ack, rsp.err}, 32'h0, "reset rsp");
        @(posedge clk_sys);
        resetn <= 1'b1;
        // Ordinary cases: apply a row, then check both words live and read.
        foreach (rows[i]) begin
            @(posedge clk_sys);
            pinIn    <= rows[i].pin;
            outState <= rows[i].outs;
            cfg      <= rows[i].cfg;
            settle();
            check(inWord, rows[i].expIn, "inWord");
            check(outWord, rows[i].expOut, "outWord");
            dio_ctrl_model_i.access(1'b0, `DIO_PAR_INPUT, 32'h0, ans);
            check(ans.data, rows[i].expIn, "read in");
            check({30'h0, ans.ack, ans.err}, 32'h2, "read in ack");
            dio_ctrl_model_i.access(1'b0, `DIO_PAR_OUTPUT, 32'h0, ans);
            check(ans.data, rows[i].expOut, "read out");
            check({30'h0, ans.ack, ans.err}, 32'h2, "read out ack");
        end
        // A write is refused and changes neither the answer data nor the word.
        dio_ctrl_model_i.access(1'b1, `DIO_PAR_INPUT, 32'hFFFF_FFFF, ans);
        check({30'h0, ans.ack, ans.err}, 32'h3, "write err");
        check(ans.data, 32'h0003_0000, "write data");
        check(inWord, 32'h0006_0000, "write word");
        // Unknown parameter numbers read as errors with zero data.
        dio_ctrl_model_i.access(1'b0, 16'h0299, 32'h0, ans);
        check(ans.data, 32'h0, "unknown data");
        check({30'h0, ans.ack, ans.err}, 32'h3, "unknown err");
        // A second reset in mid-run clears the words while pins stay on.
        @(posedge clk_sys);
        resetn <= 1'b0;
        #1;
        check(inWord | outWord | rsp.data, 32'h0, "mid reset");
        check({30'h0, rsp.ack, rsp.err}, 32'h0, "mid reset rsp");
        @(posedge clk_sys);
        resetn <= 1'b1;
        settle();
        check(inWord, 32'h0006_0000, "after reset");
        check(outWord, 32'h0003_0000, "after reset out");
        stop_test();
    end
endmodule : drive_io_state_readback_bench
